// File: verilog/power_state_machine.v
// Top-level power state machine with its AHB-Lite register slave.
`timescale 1ns/100ps
// Functional notes
// - After rail POR, load fuses to mirror; also functional regs if source pin says.
// - CRC fail on a fuse load sets trim or fuse load error flag.
// - No load errors: set backup supply from fuse bits, go quiet off.
// - Low power off select resets to 0 at undervoltage; then wait in quiet off.
// - Select at 1 and no event: move quiet off to ready off, wait.
// - Power-up events are ignored while any fuse load error is set.
// - Select 0, prototype off, no errors: event goes straight to power-up.
// - Level mode from ready off: power-on high plus supply, thermal, error checks.
// - Edge mode from ready off: power-on falling edge with the same checks.
// - Enter system-on when the power-up sequence releases the host reset.
// - Level mode: power-on low in system-on starts turn-off.
// - Edge mode: falling edge held low beyond hold time starts turn-off.
// - Software off request starts a shutdown timer; expiry starts turn-off.
// - Enabled overvoltage lasting past debounce gives a non-fault turn-off.
// - Fault timer, fault count at limit or thermal shutdown: fault power-down.
// - Power-up sequence failure goes straight to fault power-down.
// - Requested or protective power-down ends in quiet off.
// - Fault power-down ends in the fault transition state.
// - Fault transition bumps the system fault counter, then quiet off.
// - Undervoltage with a valid coin cell in quiet off or ready off enters the coin cell state.
// - In ready off with I/O supply present, mirror registers are bus accessible.
// - Ready off to power-up copies default configuration to functional regs.
// - Watchdog reset: back to system-on after delay, or fault path at limit.
// - Run and standby follow standby input XOR polarity invert bit.
`include "pmic_psm_regs.vh"

module power_state_machine #(
   parameter SDWN_CYC = (`SDWN_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter HOLD_CYC = (`HOLD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   // Clock and reset.
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave.
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // Supply and comparator status.
   input  wire        rails_por_ok,
   input  wire        vin_above_uv,
   input  wire        vin_overvoltage,
   input  wire        tj_over_tsd,
   input  wire        coin_cell_valid,
   input  wire        io_supply_ok,
   input  wire        fuse_source_select_pin,
   input  wire        prototype_config_enable,
   input  wire        self_test_error,
   // Host pins.
   input  wire        power_on_input,
   input  wire        standby_input,
   input  wire        wd_hard_reset,
   // Fuse loader.
   output reg         fuse_load_req,
   input  wire        fuse_load_done,
   input  wire        trim_crc_fail,
   input  wire        fuse_crc_fail,
   input  wire [31:0] fuse_cfg_word,
   output reg         func_load_req,
   output reg  [1:0]  backup_supply_cfg,
   // Sequencers and fault monitors.
   output reg         pup_req,
   input  wire        pup_done_reset_released,
   input  wire        pup_fail,
   output reg         pdn_req,
   input  wire        pdn_done,
   input  wire        fault_timer_expired,
   input  wire [3:0]  regulator_fault_count,
   // State view.
   output reg  [3:0]  psm_state,
   output reg         in_standby
);

   // State codes.
   localparam [3:0] ST_LOAD = 4'h0, ST_QOFF = 4'h1, ST_ROFF = 4'h2,
                    ST_PUP  = 4'h3, ST_RUN  = 4'h4, ST_STBY = 4'h5,
                    ST_WDR  = 4'h6, ST_PDN  = 4'h7, ST_PDF  = 4'h8,
                    ST_FTR  = 4'h9, ST_COIN = 4'ha, ST_WAIT = 4'hb;
   localparam [19:0] WDR_CYC =
      (`WDR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam [19:0] OV_CYC =
      (`OV_DBNC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam [19:0] SDWN_C = SDWN_CYC[19:0];
   localparam [19:0] HOLD_C = HOLD_CYC[19:0];

   // Saturating counter step.
   function [19:0] count_up;
      input [19:0] c;
      begin
         count_up = (c == 20'hfffff) ? c : c + 20'h00001;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers.
   reg  [6:0] sync1_r;
   reg  [6:0] sync2_r;
   reg        pon_d_r;
   wire pon_s   = sync2_r[0];
   wire stby_s  = sync2_r[1];
   wire wd_s    = sync2_r[2];
   wire uv_ok   = sync2_r[3];
   wire ov_s    = sync2_r[4];
   wire tsd_s   = sync2_r[5];
   wire coin_s  = sync2_r[6];
   wire pon_fall = pon_d_r & ~pon_s;

   // Two flops per input; the first feeds only the second.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r <= 7'h00;
         sync2_r <= 7'h00;
         pon_d_r <= 1'b0;
      end else begin
         sync1_r <= {coin_cell_valid, tj_over_tsd, vin_overvoltage,
                     vin_above_uv, wd_hard_reset, standby_input,
                     power_on_input};
         sync2_r <= sync1_r;
         pon_d_r <= pon_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers and state.
   reg  [3:0]  state_r;
   reg  [3:0]  state_nxt;
   reg  [3:0]  ctrl_r;
   reg  [7:0]  limit_r;
   reg  [31:0] mirror_r;
   reg         edge_mode_r;
   reg         trim_err_r;
   reg         fuse_err_r;
   reg  [3:0]  sys_regulator_fault_count_r;
   reg  [3:0]  wd_cnt_r;
   reg  [19:0] wait_cnt_r;
   reg  [19:0] sdwn_cnt_r;
   reg  [19:0] hold_cnt_r;
   reg  [19:0] ov_cnt_r;
   reg         hold_arm_r;
   reg         load_busy_r;
   reg         ap_valid_r;
   reg         ap_write_r;
   reg  [11:0] ap_addr_r;

   wire lpo      = ctrl_r[`CTRL_LPO_BIT];
   wire sw_off   = ctrl_r[`CTRL_SWOFF_BIT];
   wire ov_en    = ctrl_r[`CTRL_OVEN_BIT];
   wire stby_inv = ctrl_r[`CTRL_STBYINV_BIT];
   wire load_err = trim_err_r | fuse_err_r;
   wire any_err  = load_err | self_test_error;
   wire sys_on   = (state_r == ST_RUN) || (state_r == ST_STBY);
   wire mirror_ok = (state_r == ST_ROFF) && io_supply_ok;

   // Power-up event and its supply, thermal and error qualification.
   wire pwr_evt = edge_mode_r ? pon_fall : pon_s;
   wire qual    = uv_ok & ~(ov_s & ov_en) & ~tsd_s & ~any_err;

   // Turn-off causes within system-on.
   wire reg_fault = fault_timer_expired | tsd_s |
      (regulator_fault_count == limit_r[`LIMIT_REG_LSB +: 4]);
   wire req_off = edge_mode_r ? (hold_arm_r && hold_cnt_r > HOLD_C)
                              : ~pon_s;
   wire swoff_exp = sw_off && sdwn_cnt_r >= SDWN_C;
   wire ov_exp    = ov_en && ov_cnt_r > OV_CYC;
   wire want_stby = stby_s ^ stby_inv;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_WAIT: begin
            if (rails_por_ok)
               state_nxt = ST_LOAD;
         end
         ST_LOAD: begin
            if (fuse_load_done)
               state_nxt = ST_QOFF;
         end
         ST_QOFF: begin
            if (!uv_ok && coin_s)
               state_nxt = ST_COIN;
            else if (load_err)
               state_nxt = ST_QOFF;
            else if (!lpo && !prototype_config_enable && pwr_evt && qual)
               state_nxt = ST_PUP;
            else if (lpo || prototype_config_enable)
               state_nxt = ST_ROFF;
         end
         ST_ROFF: begin
            if (!uv_ok && coin_s)
               state_nxt = ST_COIN;
            else if (load_err)
               state_nxt = ST_ROFF;
            else if (!lpo && !prototype_config_enable)
               state_nxt = ST_QOFF;
            else if (pwr_evt && qual)
               state_nxt = ST_PUP;
         end
         ST_COIN: begin
            if (uv_ok)
               state_nxt = ST_QOFF;
         end
         ST_PUP: begin
            if (pup_fail)
               state_nxt = ST_PDF;
            else if (pup_done_reset_released)
               state_nxt = ST_RUN;
         end
         ST_RUN, ST_STBY: begin
            if (reg_fault)
               state_nxt = ST_PDF;
            else if (wd_s)
               state_nxt = ST_WDR;
            else if (req_off || swoff_exp || ov_exp)
               state_nxt = ST_PDN;
            else if (want_stby)
               state_nxt = ST_STBY;
            else
               state_nxt = ST_RUN;
         end
         ST_WDR: begin
            if (wd_cnt_r == limit_r[`LIMIT_WD_LSB +: 4])
               state_nxt = ST_PDF;
            else if (wait_cnt_r >= WDR_CYC)
               state_nxt = ST_RUN;
         end
         ST_PDN: begin
            if (pdn_done)
               state_nxt = ST_QOFF;
         end
         ST_PDF: begin
            if (pdn_done)
               state_nxt = ST_FTR;
         end
         ST_FTR: begin
            state_nxt = ST_QOFF;
         end
         default: begin
            state_nxt = ST_WAIT;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // State register, request pulses, counters and timers.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r           <= ST_WAIT;
         psm_state         <= ST_WAIT;
         in_standby        <= 1'b0;
         pup_req           <= 1'b0;
         pdn_req           <= 1'b0;
         fuse_load_req     <= 1'b0;
         func_load_req     <= 1'b0;
         backup_supply_cfg <= 2'h0;
         mirror_r          <= 32'h00000000;
         edge_mode_r       <= 1'b0;
         trim_err_r        <= 1'b0;
         fuse_err_r        <= 1'b0;
         load_busy_r       <= 1'b0;
         sys_regulator_fault_count_r   <= 4'h0;
         wd_cnt_r          <= 4'h0;
         wait_cnt_r        <= 20'h00000;
         sdwn_cnt_r        <= 20'h00000;
         hold_cnt_r        <= 20'h00000;
         ov_cnt_r          <= 20'h00000;
         hold_arm_r        <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         psm_state  <= state_nxt;
         in_standby <= (state_nxt == ST_STBY);
         // One-cycle requests on entry to a sequencer state.
         pup_req <= (state_nxt == ST_PUP) && (state_r != ST_PUP);
         pdn_req <= (state_nxt != state_r) &&
                    (state_nxt == ST_PDN || state_nxt == ST_PDF);
         fuse_load_req <= (state_nxt == ST_LOAD) && (state_r != ST_LOAD);
         func_load_req <= 1'b0;
         // Fuse load result into the mirror and error flags.
         if (state_r == ST_LOAD && fuse_load_done) begin
            mirror_r    <= fuse_cfg_word;
            edge_mode_r <= fuse_cfg_word[`FUSE_EDGE_BIT];
            trim_err_r  <= trim_crc_fail;
            fuse_err_r  <= fuse_crc_fail;
            func_load_req <= fuse_source_select_pin;
            if (!trim_crc_fail && !fuse_crc_fail)
               backup_supply_cfg <=
                  fuse_cfg_word[`FUSE_BKUP_LSB +: `FUSE_BKUP_W];
         end else if (mirror_ok && ap_valid_r && ap_write_r &&
                      ap_addr_r == `OFS_MIRROR) begin
            mirror_r <= hwdata;
         end
         // Defaults copied on every entry to power-up, from quiet off or ready off.
         if (state_nxt == ST_PUP && state_r != ST_PUP)
            func_load_req <= 1'b1;
         load_busy_r <= (state_r == ST_LOAD);
         // Fault transition bumps the system fault counter.
         if (state_r == ST_FTR && sys_regulator_fault_count_r != 4'hf)
            sys_regulator_fault_count_r <= sys_regulator_fault_count_r + 4'h1;
         // Watchdog event counter and delay in the reset state.
         if (state_nxt == ST_WDR && state_r != ST_WDR)
            wd_cnt_r <= wd_cnt_r + 4'h1;
         if (state_r == ST_WDR)
            wait_cnt_r <= count_up(wait_cnt_r);
         else
            wait_cnt_r <= 20'h00000;
         // Shutdown timer from the software off request.
         if (sys_on && sw_off)
            sdwn_cnt_r <= count_up(sdwn_cnt_r);
         else
            sdwn_cnt_r <= 20'h00000;
         // Overvoltage debounce.
         if (sys_on && ov_s)
            ov_cnt_r <= count_up(ov_cnt_r);
         else
            ov_cnt_r <= 20'h00000;
         // Edge-mode turn-off hold: armed by a fall, cleared by a rise.
         if (!sys_on || pon_s) begin
            hold_arm_r <= 1'b0;
            hold_cnt_r <= 20'h00000;
         end else if (pon_fall) begin
            hold_arm_r <= 1'b1;
            hold_cnt_r <= 20'h00001;
         end else if (hold_arm_r) begin
            hold_cnt_r <= count_up(hold_cnt_r);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: address phase capture and read data.
   wire ap_take = hsel & htrans[1] & hready;

   // Read data is formed at the address phase and stands in the data phase.
   function [31:0] read_mux;
      input [11:0] a;
      begin
         case (a)
            `OFS_CTRL:   read_mux = {28'h0000000, ctrl_r};
            `OFS_STATUS: read_mux = {16'h0000, wd_cnt_r, sys_regulator_fault_count_r,
                                     1'b0, self_test_error, fuse_err_r,
                                     trim_err_r, state_r};
            `OFS_LIMIT:  read_mux = {24'h000000, limit_r};
            `OFS_MIRROR: read_mux = mirror_ok ? mirror_r : 32'h00000000;
            default:     read_mux = 32'h00000000;
         endcase
      end
   endfunction

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_addr_r  <= 12'h000;
         hrdata     <= 32'h00000000;
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
      end else begin
         hreadyout  <= 1'b1;
         hresp      <= 1'b0;
         ap_valid_r <= ap_take;
         if (ap_take) begin
            ap_write_r <= hwrite;
            ap_addr_r  <= {haddr[11:2], 2'b00};
            hrdata     <= hwrite ? 32'h00000000
                                 : read_mux({haddr[11:2], 2'b00});
         end
      end
   end

   // Register writes land in the data phase.
   wire dp_wr = ap_valid_r & ap_write_r;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r  <= `CTRL_RESET;
         limit_r <= `LIMIT_RESET;
      end else begin
         if (dp_wr && ap_addr_r == `OFS_CTRL)
            ctrl_r <= hwdata[3:0];
         else if (state_r == ST_PDN || state_r == ST_PDF)
            ctrl_r[`CTRL_SWOFF_BIT] <= 1'b0;
         if (!uv_ok)
            ctrl_r[`CTRL_LPO_BIT] <= 1'b0;
         if (dp_wr && ap_addr_r == `OFS_LIMIT)
            limit_r <= hwdata[7:0];
      end
   end

endmodule // power_state_machine

// File: verilog/pmic_psm_regs.vh
// Register offsets, fields, reset values and timing for the power state machine.
`ifndef PMIC_PSM_REGS_VH
`define PMIC_PSM_REGS_VH

// Register byte offsets on the bus.
`define OFS_CTRL            12'h000
`define OFS_STATUS          12'h004
`define OFS_LIMIT           12'h008
`define OFS_MIRROR          12'h00c

// Control register fields.
`define CTRL_LPO_BIT        0
`define CTRL_SWOFF_BIT      1
`define CTRL_OVEN_BIT       2
`define CTRL_STBYINV_BIT    3
`define CTRL_RESET          4'h0

// Limit register fields and reset value.
`define LIMIT_REG_LSB       0
`define LIMIT_WD_LSB        4
`define LIMIT_RESET         8'hff

// Fuse configuration word fields.
`define FUSE_EDGE_BIT       0
`define FUSE_BKUP_LSB       1
`define FUSE_BKUP_W         2

// Timing, in nanoseconds, and the clock period.
`define CLK_PERIOD_NS       50
`define SDWN_TIME_NS        500000
`define WDR_DELAY_NS        30000
`define HOLD_TIME_NS        4000000
`define OV_DBNC_NS          10000

`endif

// File: verif/psm_seq_model.sv
// Behavioural fuse loader and rail sequencers facing the state machine.
`timescale 1ns/100ps
module psm_seq_model (
   // Clock, reset and pace.
   input  wire hclk,
   input  wire hresetn,
   input  wire slow,
   // Requests from the state machine.
   input  wire fuse_load_req,
   input  wire pup_req,
   input  wire pdn_req,
   // Completion pulses back.
   output reg  fuse_load_done,
   output reg  pup_done,
   output reg  pdn_done
);
   reg [3:0] ld_cnt_r, pu_cnt_r, pd_cnt_r;
   wire [3:0] lat = slow ? 4'h8 : 4'h2;
   ////////////////////////////////////////////////////////////////////
   // Each request starts a countdown; a done pulse ends it.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {ld_cnt_r, pu_cnt_r, pd_cnt_r} <= 12'h000;
         {fuse_load_done, pup_done, pdn_done} <= 3'h0;
      end else begin
         ld_cnt_r <= fuse_load_req ? lat : ld_cnt_r - (ld_cnt_r != 0);
         pu_cnt_r <= pup_req ? lat : pu_cnt_r - (pu_cnt_r != 0);
         pd_cnt_r <= pdn_req ? lat : pd_cnt_r - (pd_cnt_r != 0);
         fuse_load_done <= (ld_cnt_r == 4'h1);
         pup_done <= (pu_cnt_r == 4'h1);
         pdn_done <= (pd_cnt_r == 4'h1);
      end
   end
endmodule // psm_seq_model

// File: verif/psm_asserts.sv
// Concurrent checks on the power state machine ports.
`timescale 1ns/100ps
module psm_asserts (
   // Clock and reset.
   input wire       hclk,
   input wire       hresetn,
   // Observed ports.
   input wire       hreadyout,
   input wire       hresp,
   input wire [3:0] psm_state,
   input wire       pup_req,
   input wire       func_load_req,
   input wire       pdn_req,
   input wire       pdn_done,
   input wire       fuse_load_done,
   input wire       fault_timer_expired,
   input wire       self_test_error
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////
   // The fault transition lasts one cycle and lands in quiet off.
   sequence s_ftr_exit;
      psm_state == 4'h9 ##1 psm_state == 4'h1;
   endsequence
   sequence s_pup_entry;
      psm_state == 4'h3 && $past(psm_state) != 4'h3;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   a_pup_pulse: assert property (pup_req |=> !pup_req)
      else $error("power-up request longer than one cycle");
   a_pup_copy: assert property (s_pup_entry |-> pup_req && func_load_req)
      else $error("power-up entered without requests");
   a_pup_source: assert property (s_pup_entry |->
      $past(psm_state) inside {4'h1, 4'h2} && !$past(self_test_error))
      else $error("power-up entered from a wrong state");
   a_pdn_start: assert property (psm_state inside {4'h7, 4'h8} &&
      !($past(psm_state) inside {4'h7, 4'h8}) |-> pdn_req)
      else $error("power-down entered without request");
   a_pdn_quiet: assert property (psm_state == 4'h7 && pdn_done
      |-> ##[1:3] psm_state == 4'h1)
      else $error("turn-off did not end in quiet off");
   a_pdf_ftr: assert property (psm_state == 4'h8 && pdn_done
      |-> ##[1:3] s_ftr_exit)
      else $error("fault power-down did not pass fault transition");
   a_fault_exit: assert property (psm_state inside {4'h4, 4'h5} &&
      fault_timer_expired |-> ##[1:3] psm_state == 4'h8)
      else $error("fault timer ignored in system-on");
   a_load_end: assert property (psm_state == 4'h0 && fuse_load_done
      |-> ##[1:3] psm_state == 4'h1)
      else $error("fuse load did not reach quiet off");
endmodule // psm_asserts

// File: verif/pmic_power_state_machine_tb.sv
// Self-checking bench for the power state machine.
`timescale 1ns/100ps
module pmic_power_state_machine_tb;
   logic        hclk, hresetn, hsel, hwrite, pon, stby, trim_f, ftmr, io_ok;
   logic        slow, por, uv_ok, ovl, thermal_shutdown_limit, coin, fsrc, proto, stest, wdr;
   logic        fcrc;
   logic [11:0] haddr;
   logic [1:0]  htrans, backup_supply_cfg;
   logic [2:0]  hsize;
   logic [3:0]  rfc, psm_state;
   logic [31:0] hwdata, hrdata, fuse_cfg_word, rd;
   wire         hready, hreadyout, hresp, fuse_load_req, fuse_load_done;
   wire         func_load_req, pup_req, pup_done, pdn_req, pdn_done, in_stb;
   integer      bad_count, n_checks, cyc;
   assign hready = hreadyout;
   power_state_machine #(.SDWN_CYC(20), .HOLD_CYC(20)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rails_por_ok(por), .vin_above_uv(uv_ok), .vin_overvoltage(ovl),
      .tj_over_tsd(thermal_shutdown_limit), .coin_cell_valid(coin), .io_supply_ok(io_ok),
      .fuse_source_select_pin(fsrc), .prototype_config_enable(proto),
      .self_test_error(stest), .power_on_input(pon), .standby_input(stby),
      .wd_hard_reset(wdr), .fuse_load_req(fuse_load_req),
      .fuse_load_done(fuse_load_done), .trim_crc_fail(trim_f),
      .fuse_crc_fail(fcrc), .fuse_cfg_word(fuse_cfg_word),
      .func_load_req(func_load_req), .backup_supply_cfg(backup_supply_cfg),
      .pup_req(pup_req), .pup_done_reset_released(pup_done),
      .pup_fail(1'b0), .pdn_req(pdn_req), .pdn_done(pdn_done),
      .fault_timer_expired(ftmr), .regulator_fault_count(rfc),
      .psm_state(psm_state), .in_standby(in_stb));
   psm_seq_model u_seq (.hclk(hclk), .hresetn(hresetn), .slow(slow),
      .fuse_load_req(fuse_load_req), .pup_req(pup_req), .pdn_req(pdn_req),
      .fuse_load_done(fuse_load_done), .pup_done(pup_done),
      .pdn_done(pdn_done));
   ////////////////////////////////////////////////////////////////////
   // Clock and a cycle ceiling against hangs.
   always #25 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         bad_count = bad_count + 1;
         final_report;
      end
   end
   // Compares one value and counts the outcome.
   task check(input string nm, input logic [31:0] got, exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One single AHB-Lite word transfer; read data taken at the data edge.
   task bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // Polls the state view with a bounded wait, then compares it.
   task wait_st(input logic [3:0] s);
      integer i;
      i = 0;
      while (psm_state !== s && i < 3000) begin
         @(negedge hclk);
         i = i + 1;
      end
      check("psm_state", psm_state, s);
   endtask
   task do_reset;
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      check("reset state", psm_state, 4'hb);
      hresetn <= 1'b1;
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Main sequence of tests.
   initial begin
      {hsel, hwrite, pon, stby, trim_f, ftmr, slow, ovl, thermal_shutdown_limit} = 9'h000;
      {coin, fsrc, proto, stest, wdr, fcrc, hclk, hresetn} = 8'h00;
      haddr = 12'h000; htrans = 2'b00; hsize = 3'b010; hwdata = 32'h0;
      io_ok = 1'b1; por = 1'b1; uv_ok = 1'b1; rfc = 4'h0;
      fuse_cfg_word = 32'h0000_0004; bad_count = 0; n_checks = 0; cyc = 0;
      do_reset;
      wait_st(4'h1);
      check("backup cfg", backup_supply_cfg, 2'h2);
      bus(`OFS_CTRL, 1'b0, 32'h0);
      check("ctrl reset", rd, 32'h0);
      bus(`OFS_LIMIT, 1'b0, 32'h0);
      check("limit reset", rd, 32'hff);
      bus(12'h010, 1'b0, 32'h0);
      check("unmapped", rd, 32'h0);
      bus(`OFS_STATUS, 1'b0, 32'h0);
      check("load errors", rd & 32'h30, 32'h0);
      $display("test boot done");
      pon <= 1'b1;
      wait_st(4'h3);
      wait_st(4'h4);
      stby <= 1'b1;
      wait_st(4'h5);
      check("standby out", in_stb, 1'b1);
      stby <= 1'b0;
      wait_st(4'h4);
      pon <= 1'b0;
      wait_st(4'h7);
      wait_st(4'h1);
      $display("test level on off done");
      bus(`OFS_CTRL, 1'b1, 32'h1);
      wait_st(4'h2);
      bus(`OFS_MIRROR, 1'b1, 32'h5a5a_c3c3);
      bus(`OFS_MIRROR, 1'b0, 32'h0);
      check("mirror", rd, 32'h5a5a_c3c3);
      slow <= 1'b1;
      pon <= 1'b1;
      wait_st(4'h3);
      wait_st(4'h4);
      bus(`OFS_CTRL, 1'b1, 32'h3);
      repeat (10) @(negedge hclk);
      check("timer running", psm_state, 4'h4);
      wait_st(4'h7);
      wait_st(4'h3);
      wait_st(4'h4);
      $display("test soft off done");
      ftmr <= 1'b1;
      pon <= 1'b0;
      wait_st(4'h8);
      ftmr <= 1'b0;
      wait_st(4'h9);
      wait_st(4'h2);
      bus(`OFS_STATUS, 1'b0, 32'h0);
      check("fault count", rd[11:8], 4'h1);
      $display("test fault done");
      trim_f <= 1'b1;
      do_reset;
      wait_st(4'h1);
      bus(`OFS_STATUS, 1'b0, 32'h0);
      check("trim error", rd[4], 1'b1);
      pon <= 1'b1;
      repeat (30) @(negedge hclk);
      check("ignored event", psm_state, 4'h1);
      $display("test load error done");
      // Edge mode from the fuse word, with a watchdog reset in system-on.
      trim_f <= 1'b0;
      fuse_cfg_word <= 32'h0000_0005;
      do_reset;
      wait_st(4'h1);
      pon <= 1'b0;
      wait_st(4'h3);
      wait_st(4'h4);
      wdr <= 1'b1;
      wait_st(4'h6);
      wdr <= 1'b0;
      wait_st(4'h4);
      pon <= 1'b1;
      repeat (5) @(negedge hclk);
      pon <= 1'b0;
      repeat (10) @(negedge hclk);
      check("hold running", psm_state, 4'h4);
      wait_st(4'h7);
      wait_st(4'h1);
      $display("test edge mode done");
      final_report;
   end
endmodule // pmic_power_state_machine_tb
bind power_state_machine psm_asserts u_chk (.hclk(hclk), .hresetn(hresetn),
   .hreadyout(hreadyout), .hresp(hresp), .psm_state(psm_state),
   .pup_req(pup_req), .func_load_req(func_load_req), .pdn_req(pdn_req),
   .pdn_done(pdn_done), .fuse_load_done(fuse_load_done),
   .fault_timer_expired(fault_timer_expired),
   .self_test_error(self_test_error));
